// ### shared/fmis_pkg.sv
// Purpose : Shared constants and types for the two-wire memory slave
// Assumes : Bus master owns the clock line; device only answers
// Notes   : One-hot state codes are written out explicitly

package fmis_pkg;

   // ----------------------------------------------------------------
   // Array geometry
   // ----------------------------------------------------------------
   localparam int ROW_W   = 8;
   localparam int SEG_W   = 3;
   localparam int ADDR_W  = SEG_W + ROW_W;
   localparam int DATA_W  = 8;
   localparam int DEPTH   = 2048;

   // ----------------------------------------------------------------
   // Address byte fields and protocol constants
   // ----------------------------------------------------------------
   localparam logic [3:0] DEV_TYPE    = 4'ha;
   localparam int         TYPE_MSB    = 7;
   localparam int         TYPE_LSB    = 4;
   localparam int         SEG_MSB     = 3;
   localparam int         SEG_LSB     = 1;
   localparam int         RW_BIT      = 0;
   localparam logic [3:0] BYTE_BITS   = 4'h8;
   localparam int         SYNC_STAGES = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [SYNC_STAGES-1:0] SCL_RST  = 3'h7;
   localparam logic [SYNC_STAGES-1:0] SDA_RST  = 3'h7;
   localparam logic [SYNC_STAGES-1:0] WP_RST   = 3'h0;
   localparam logic [ADDR_W-1:0]      ADDR_RST = 11'h000;
   localparam logic [DATA_W-1:0]      BYTE_RST = 8'h00;

   // ----------------------------------------------------------------
   // Slave states
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_DEV  = 7'h02,
      S_WORD = 7'h04,
      S_WDAT = 7'h08,
      S_ACK  = 7'h10,
      S_RDAT = 7'h20,
      S_MACK = 7'h40
   } fmis_state_e;

endpackage

// ### shared/fmis_mem_if.sv
// Purpose : Carries array access between slave control and storage
// Assumes : Single clock; read data appears one cycle after address
// Notes   : Write takes effect on the edge where we is high
`timescale 1ns/1ps

interface fmis_mem_if;
   logic                             we;
   logic [fmis_pkg::ADDR_W-1:0]      wa;
   logic [fmis_pkg::DATA_W-1:0]      wd;
   logic [fmis_pkg::ADDR_W-1:0]      ra;
   logic [fmis_pkg::DATA_W-1:0]      rd;

   modport ctrl  (output we, output wa, output wd, output ra, input rd);
   modport store (input we, input wa, input wd, input ra, output rd);
endinterface

// ### core/fmis_array.sv
// Purpose : Byte-wide storage array of the memory slave
// Assumes : Contents are undefined until written
// Notes   : Writes complete in one clock, so no busy state exists
`timescale 1ns/1ps

module fmis_array (
   input  wire logic  clock_i,
   fmis_mem_if.store  mem
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [fmis_pkg::DATA_W-1:0] cells [fmis_pkg::DEPTH];

   // One write port and one registered read port
   always_ff @(posedge clock_i) begin
      if (mem.we) begin
         cells[mem.wa] <= mem.wd;
      end
      mem.rd <= cells[mem.ra];
   end

endmodule

// ### core/fmis_slave.sv
// Purpose : Two-wire slave front end of a 2048 x 8 nonvolatile memory
// Assumes : clock_i is far faster than the bus clock (at least 8x)
// Notes   : Bus pins pass three flops; a level counts when two agree
`timescale 1ns/1ps

module fmis_slave (
   input  wire logic clock_i,
   input  wire logic rstn_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic wp_i,
   output logic      sda_o,
   output logic      sda_oe_o
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [fmis_pkg::SYNC_STAGES-1:0] scl_s;
      logic [fmis_pkg::SYNC_STAGES-1:0] sda_s;
      logic [fmis_pkg::SYNC_STAGES-1:0] wp_s;
      logic                             scl_f;
      logic                             sda_f;
      logic                             wp_f;
      fmis_pkg::fmis_state_e            st;
      fmis_pkg::fmis_state_e            ack_next;
      logic [3:0]                       cnt;
      logic [fmis_pkg::DATA_W-1:0]      shift;
      logic [fmis_pkg::ADDR_W-1:0]      addr;
      logic                             oe;
      logic                             sdo;
      logic                             we;
      logic [fmis_pkg::ADDR_W-1:0]      wa;
      logic [fmis_pkg::DATA_W-1:0]      wd;
   } fmis_regs_s;

   fmis_regs_s r;
   fmis_regs_s next_r;
   fmis_mem_if mem ();

   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Settled level: follow the pin only once stages two and three agree
   function automatic logic settle(
      input logic [fmis_pkg::SYNC_STAGES-1:0] s,
      input logic                             f
   );
      return (s[1] == s[2]) ? s[2] : f;
   endfunction

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   fmis_array u_array (
      .clock_i (clock_i),
      .mem     (mem)
   );

   // Array ports come straight from the state record
   assign mem.we = r.we;
   assign mem.wa = r.wa;
   assign mem.wd = r.wd;
   assign mem.ra = r.addr;

   // Bus events, from the settled levels; the device never makes a clock
   assign scl_rise = settle(r.scl_s, r.scl_f) & ~r.scl_f;
   assign scl_fall = ~settle(r.scl_s, r.scl_f) & r.scl_f;
   assign start_ev = r.scl_f & r.sda_f
                   & ~settle(r.sda_s, r.sda_f);
   assign stop_ev  = r.scl_f & ~r.sda_f
                   & settle(r.sda_s, r.sda_f);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Start and Stop outrank bit events, since they may cut any byte
   always_comb begin
      next_r       = r;
      next_r.scl_s = {r.scl_s[1:0], scl_i};
      next_r.sda_s = {r.sda_s[1:0], sda_i};
      next_r.wp_s  = {r.wp_s[1:0], wp_i};
      next_r.scl_f = settle(r.scl_s, r.scl_f);
      next_r.sda_f = settle(r.sda_s, r.sda_f);
      next_r.wp_f  = settle(r.wp_s, r.wp_f);
      next_r.we    = 1'b0;
      next_r.sdo   = 1'b0;
      if (start_ev) begin
         next_r.st  = fmis_pkg::S_DEV;
         next_r.cnt = 4'h0;
         next_r.oe  = 1'b0;
      end else if (stop_ev) begin
         next_r.st  = fmis_pkg::S_IDLE;
         next_r.oe  = 1'b0;
      end else if (scl_rise) begin
         case (r.st)
            fmis_pkg::S_DEV,
            fmis_pkg::S_WORD,
            fmis_pkg::S_WDAT: begin
               next_r.shift = {r.shift[6:0], r.sda_f};
               next_r.cnt   = r.cnt + 4'h1;
            end
            fmis_pkg::S_RDAT: begin
               next_r.cnt = r.cnt + 4'h1;
            end
            fmis_pkg::S_MACK: begin
               // Low means the master wants another byte
               next_r.cnt = 4'h0;
               next_r.st  = r.sda_f ? fmis_pkg::S_IDLE
                                    : fmis_pkg::S_RDAT;
            end
            default: begin
               next_r.st = r.st;
            end
         endcase
      end else if (scl_fall) begin
         case (r.st)
            fmis_pkg::S_DEV: begin
               if (r.cnt == fmis_pkg::BYTE_BITS) begin
                  if (r.shift[fmis_pkg::TYPE_MSB:fmis_pkg::TYPE_LSB]
                      == fmis_pkg::DEV_TYPE) begin
                     next_r.addr[fmis_pkg::ADDR_W-1:fmis_pkg::ROW_W] =
                        r.shift[fmis_pkg::SEG_MSB:fmis_pkg::SEG_LSB];
                     next_r.oe       = 1'b1;
                     next_r.st       = fmis_pkg::S_ACK;
                     next_r.ack_next = r.shift[fmis_pkg::RW_BIT]
                                     ? fmis_pkg::S_RDAT
                                     : fmis_pkg::S_WORD;
                  end else begin
                     next_r.st = fmis_pkg::S_IDLE;
                  end
               end
            end
            fmis_pkg::S_WORD: begin
               if (r.cnt == fmis_pkg::BYTE_BITS) begin
                  next_r.addr[fmis_pkg::ROW_W-1:0] = r.shift;
                  next_r.oe       = 1'b1;
                  next_r.st       = fmis_pkg::S_ACK;
                  next_r.ack_next = fmis_pkg::S_WDAT;
               end
            end
            fmis_pkg::S_WDAT: begin
               if (r.cnt == fmis_pkg::BYTE_BITS) begin
                  if (r.wp_f) begin
                     // Protected: no ack, no address step, transfer ends
                     next_r.st = fmis_pkg::S_IDLE;
                  end else begin
                     next_r.we       = 1'b1;
                     next_r.wa       = r.addr;
                     next_r.wd       = r.shift;
                     next_r.addr     = r.addr + 11'h001;
                     next_r.oe       = 1'b1;
                     next_r.st       = fmis_pkg::S_ACK;
                     next_r.ack_next = fmis_pkg::S_WDAT;
                  end
               end
            end
            fmis_pkg::S_ACK: begin
               next_r.cnt = 4'h0;
               next_r.st  = r.ack_next;
               next_r.oe  = 1'b0;
               if (r.ack_next == fmis_pkg::S_RDAT) begin
                  next_r.shift = mem.rd;
                  next_r.oe    = ~mem.rd[7];
               end
            end
            fmis_pkg::S_RDAT: begin
               if (r.cnt == 4'h0) begin
                  next_r.shift = mem.rd;
                  next_r.oe    = ~mem.rd[7];
               end else if (r.cnt == fmis_pkg::BYTE_BITS) begin
                  next_r.oe   = 1'b0;
                  next_r.addr = r.addr + 11'h001;
                  next_r.st   = fmis_pkg::S_MACK;
               end else begin
                  next_r.shift = {r.shift[6:0], 1'b0};
                  next_r.oe    = ~r.shift[6];
               end
            end
            default: begin
               next_r.st = r.st;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset doubles as the power-on reset; the slave wakes idle, released
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         r.scl_s    <= fmis_pkg::SCL_RST;
         r.sda_s    <= fmis_pkg::SDA_RST;
         r.wp_s     <= fmis_pkg::WP_RST;
         r.scl_f    <= fmis_pkg::SCL_RST[0];
         r.sda_f    <= fmis_pkg::SDA_RST[0];
         r.wp_f     <= fmis_pkg::WP_RST[0];
         r.st       <= fmis_pkg::S_IDLE;
         r.ack_next <= fmis_pkg::S_IDLE;
         r.cnt      <= 4'h0;
         r.shift    <= fmis_pkg::BYTE_RST;
         r.addr     <= fmis_pkg::ADDR_RST;
         r.oe       <= 1'b0;
         r.sdo      <= 1'b0;
         r.we       <= 1'b0;
         r.wa       <= fmis_pkg::ADDR_RST;
         r.wd       <= fmis_pkg::BYTE_RST;
      end else begin
         r <= next_r;
      end
   end

   assign sda_o    = r.sdo;
   assign sda_oe_o = r.oe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   sequence wr_byte_done;
      r.st == fmis_pkg::S_WDAT && scl_fall && !start_ev && !stop_ev
      && r.cnt == fmis_pkg::BYTE_BITS;
   endsequence

   sequence commit_pulse;
      r.we ##1 !r.we;
   endsequence

   a_sda_low_only: assert property (!sda_o)
      else $error("data line driven high");
   a_oe_on_fall: assert property (
      $changed(sda_oe_o) |-> $past(scl_fall))
      else $error("data line changed away from a falling clock");
   a_wp_blocks_wr: assert property (
      r.we |-> !$past(r.wp_f))
      else $error("array written while protected");
   a_commit_now: assert property (
      wr_byte_done and r.wp_f == 1'b0 |=> commit_pulse)
      else $error("received byte not committed at once");
   a_stop_idle: assert property (
      stop_ev && !start_ev |=> r.st == fmis_pkg::S_IDLE && !sda_oe_o)
      else $error("stop did not return to idle");
   a_start_rearm: assert property (
      start_ev |=> r.st == fmis_pkg::S_DEV && r.cnt == 4'h0)
      else $error("start did not rearm the slave");
   a_addr_wraps: assert property (
      r.we |-> r.addr == 11'(r.wa + 11'h001))
      else $error("address did not step after write");
   a_wp_no_ack: assert property (
      wr_byte_done and r.wp_f |=> !sda_oe_o && r.addr == $past(r.addr)
      ##1 r.st == fmis_pkg::S_IDLE)
      else $error("protected byte was acknowledged");
   a_idle_quiet: assert property (
      r.st == fmis_pkg::S_IDLE |-> !sda_oe_o)
      else $error("idle slave holds the data line");

endmodule

// ### verif/fmis_master.sv
// Purpose : Two-wire bus master model facing the memory slave
// Assumes : One bus bit is 8 system clocks, 5 low and 3 high
// Notes   : Data line is released (high) unless a 0 is sent
`timescale 1ns/1ps

module fmis_master (
   input  wire logic clock_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);

   // ---------------------------------------------------------------
   // Idle bus
   // ---------------------------------------------------------------
   // Both lines high so the slave flops fill with the idle level
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   // ---------------------------------------------------------------
   // Bus conditions
   // ---------------------------------------------------------------
   // Start leaves clock high and data low for the first bit
   task automatic start();
      tick(1);
      scl_o <= 1'b0;
      tick(1);
      sda_o <= 1'b1;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= 1'b0;
      tick(4);
   endtask

   // Only called while the master owns data, never mid read bit
   task automatic stop();
      tick(1);
      scl_o <= 1'b0;
      tick(1);
      sda_o <= 1'b0;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= 1'b1;
      tick(4);
      // Idle bus rests with the clock low for robustness
      scl_o <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // Bits and bytes
   // ---------------------------------------------------------------
   // Data moves one clock into the low half, so it is steady while high.
   // Low half is 5 clocks: the slave answers 4 clocks after the fall,
   // so its bit must settle before the clock rises again.
   task automatic bit_io(input logic b, output logic r);
      tick(1);
      scl_o <= 1'b0;
      tick(1);
      sda_o <= b;
      tick(4);
      scl_o <= 1'b1;
      tick(2);
      @(negedge clock_i);
      r = sda_i;
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   // Master acknowledge; a missing one ends the read
   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~ack, r);
   endtask

endmodule

// ### verif/tb.sv
// Purpose : Self-checking bench of the two-wire memory slave
// Assumes : Master model paces the bus at 320 ns per bit
// Notes   : Array content is only compared after it was written
`timescale 1ns/1ps

module tb;
   logic clock_i;
   logic rstn_i;
   logic wp_i;
   logic scl;
   logic sda_host;
   logic sda_dev;
   logic sda_oe;
   logic sda_line;
   int   errors;
   int   check_count;

   // Wired-AND line with pull-up
   assign sda_line = (sda_oe ? sda_dev : 1'b1) & sda_host;

   fmis_slave DUT (
      .clock_i  (clock_i),
      .rstn_i   (rstn_i),
      .scl_i    (scl),
      .sda_i    (sda_line),
      .wp_i     (wp_i),
      .sda_o    (sda_dev),
      .sda_oe_o (sda_oe)
   );

   fmis_master master (
      .clock_i (clock_i),
      .sda_i   (sda_line),
      .scl_o   (scl),
      .sda_o   (sda_host)
   );

   // ---------------------------------------------------------------
   // Clock, pin monitor and closing
   // ---------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   // The device may only pull low, never drive high
   always @(posedge clock_i) begin
      if (sda_oe === 1'b1 && sda_dev !== 1'b0) begin
         errors++;
         $display("MISMATCH %0t data driven high", $time);
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string m);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Transaction helpers
   // ---------------------------------------------------------------
   // Start, device byte and word address; bus stays held
   task automatic addr(input logic [2:0] seg, input logic [7:0] row);
      logic a;
      master.start();
      master.put_byte({fmis_pkg::DEV_TYPE, seg, 1'b0}, a);
      chk(a, 8'h01, "device ack");
      master.put_byte(row, a);
      chk(a, 8'h01, "word ack");
   endtask

   task automatic wr(input logic [2:0] seg, input logic [7:0] row,
                     input logic [7:0] d[$]);
      logic a;
      addr(seg, row);
      foreach (d[i]) begin
         master.put_byte(d[i], a);
         chk(a, 8'h01, "data ack");
      end
      master.stop();
   endtask

   // Last byte gets no master ack so the slave lets go of the line
   task automatic rd(input logic [2:0] seg, input logic [7:0] e[$]);
      logic       a;
      logic [7:0] v;
      master.start();
      master.put_byte({fmis_pkg::DEV_TYPE, seg, 1'b1}, a);
      chk(a, 8'h01, "read ack");
      foreach (e[i]) begin
         master.get_byte(i != e.size() - 1, v);
         chk(v, e[i], "read data");
      end
      master.stop();
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Bits clocked without a Start are ignored
   task automatic t_idle();
      logic a;
      chk(sda_oe, 8'h00, "oe after reset");
      master.put_byte({fmis_pkg::DEV_TYPE, 3'h0, 1'b0}, a);
      chk(a, 8'h00, "ack without start");
   endtask

   // Back-to-back writes, segment select and sequential read
   task automatic t_write_read();
      wr(3'h2, 8'h10, '{8'h5a, 8'ha5, 8'h3c});
      wr(3'h5, 8'h10, '{8'h77});
      addr(3'h2, 8'h10);
      rd(3'h5, '{8'h77});
      rd(3'h2, '{8'ha5, 8'h3c});
   endtask

   // Top location rolls over to location zero
   task automatic t_wrap();
      wr(3'h7, 8'hff, '{8'hc3, 8'h3c});
      addr(3'h7, 8'hff);
      rd(3'h7, '{8'hc3, 8'h3c});
   endtask

   // Protected write is refused and leaves address and data alone
   task automatic t_protect();
      logic a;
      wr(3'h1, 8'h20, '{8'h11});
      wp_i <= 1'b1;
      addr(3'h1, 8'h20);
      master.put_byte(8'h99, a);
      chk(a, 8'h00, "protected ack");
      master.stop();
      wp_i <= 1'b0;
      rd(3'h1, '{8'h11});
   endtask

   // Partial bytes cut by Start or Stop are dropped
   task automatic t_abort();
      logic a;
      logic r;
      wr(3'h3, 8'h40, '{8'h42});
      addr(3'h3, 8'h40);
      repeat (4) master.bit_io(1'b1, r);
      master.start();
      master.put_byte({4'h5, 3'h3, 1'b0}, a);
      chk(a, 8'h00, "foreign type ack");
      master.stop();
      addr(3'h3, 8'h40);
      repeat (4) master.bit_io(1'b1, r);
      master.stop();
      rd(3'h3, '{8'h42});
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      rstn_i = 1'b0;
      wp_i = 1'b0;
      errors = 0;
      check_count = 0;
      repeat (8) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      t_idle();
      t_write_read();
      t_wrap();
      t_protect();
      t_abort();
      stop_test();
   end

   // Whole run needs well under 8000 clocks
   initial begin
      repeat (40000) @(posedge clock_i);
      errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      stop_test();
   end

endmodule
